// File: cirq_pkg.sv
// package for the core interrupt and configuration register block
// assumes an 8-bit register port with one-cycle read latency
package cirq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INTCTL_B0 = 8'h0B;
  localparam logic [7:0] ADDR_INTCTL_B1 = 8'h8B;
  localparam logic [7:0] ADDR_PFLAGS    = 8'h0C;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h81;
  localparam logic [7:0] ADDR_PENABLES  = 8'h8C;
  localparam logic [7:0] ADDR_RSTCAUSE  = 8'h8E;
  localparam logic [7:0] ADDR_OSCTRIM   = 8'h90;
  localparam logic [7:0] ADDR_PINCHG    = 8'h96;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_PULLUP_DIS  = 7;
  localparam int BIT_EDGE_SEL    = 6;
  localparam int BIT_T0_SRC      = 5;
  localparam int BIT_T0_EDGE     = 4;
  localparam int BIT_PS_ASSIGN   = 3;
  localparam int BIT_GIE         = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE        = 6;
  localparam int BIT_T0_EN       = 5;
  localparam int BIT_EXT_EN      = 4;
  localparam int BIT_PC_EN       = 3;
  localparam int BIT_T0_FLAG     = 2;
  localparam int BIT_EXT_FLAG    = 1;
  localparam int BIT_PC_FLAG     = 0;
  localparam int BIT_NVM         = 7;
  localparam int BIT_CONV        = 6;
  localparam int BIT_CMP         = 3;
  localparam int BIT_TMR1        = 0;
  localparam int BIT_POR         = 1;
  localparam int BIT_BOD         = 0;

  // ---------------------------------------------------------------
  // masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PERIPH_MASK   = 8'hC9;
  localparam logic [7:0] RSTCAUSE_MASK = 8'h03;
  localparam logic [7:0] TRIM_MASK     = 8'hFC;
  localparam logic [5:0] PIN_MASK      = 6'h3F;
  localparam logic [7:0] RST_PRESCALE  = 8'hFF;
  localparam logic [7:0] RST_INTCTL    = 8'h00;
  localparam logic [7:0] RST_PERIPH    = 8'h00;
  localparam logic [5:0] RST_TRIM      = 6'h20;
  localparam logic [5:0] RST_PINCHG    = 6'h00;
  localparam logic [1:0] RST_RSTCAUSE  = 2'h3;
  localparam logic [8:0] RST_T0_DIV    = 9'h001;
  localparam logic [7:0] RST_WD_DIV    = 8'h80;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cirq_bus_t;

  typedef struct packed {
    logic       pullup_global_disable;
    logic       ext_irq_edge_select;
    logic       timer0_clock_source;
    logic       timer0_source_edge;
    logic       prescaler_assign;
    logic [2:0] prescaler_rate;
  } cirq_prescale_t;

endpackage : cirq_pkg

// File: cirq_regs.sv
// core interrupt enable/flag and configuration register block
// assumes single clock; events and pins synchronous to clk_sys_i
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module cirq_regs (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // reset causes
  input  wire logic                     por_event_i,
  input  wire logic                     bod_event_i,
  // register port
  input  wire cirq_pkg::cirq_bus_t      bus_i,
  output logic [7:0]                    rdata_o,
  // events
  input  wire logic                     timer0_ovf_i,
  input  wire logic                     ext_irq_pin_i,
  input  wire logic [5:0]               port_pins_i,
  input  wire logic                     port_read_i,
  input  wire logic                     nvm_write_done_i,
  input  wire logic                     conversion_done_i,
  input  wire logic                     comparator_change_i,
  input  wire logic                     timer1_ovf_i,
  // interrupt request and configuration outputs
  output logic                          irq_o,
  output cirq_pkg::cirq_prescale_t      prescale_o,
  output logic                          pullups_enabled_o,
  output logic [8:0]                    timer0_div_o,
  output logic [7:0]                    watchdog_div_o,
  output logic [5:0]                    osc_trim_field_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  logic wr_intctl;
  logic wr_pflags;
  logic wr_prescale;
  logic wr_penables;
  logic wr_rstcause;
  logic wr_trim;
  logic wr_pinchg;
  assign wr_intctl   = bus_i.wr && (hit(bus_i.addr, cirq_pkg::ADDR_INTCTL_B0)
                       || hit(bus_i.addr, cirq_pkg::ADDR_INTCTL_B1));
  assign wr_pflags   = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_PFLAGS);
  assign wr_prescale = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_PRESCALE);
  assign wr_penables = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_PENABLES);
  assign wr_rstcause = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_RSTCAUSE);
  assign wr_trim     = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_OSCTRIM);
  assign wr_pinchg   = bus_i.wr && hit(bus_i.addr, cirq_pkg::ADDR_PINCHG);

  // ---------------------------------------------------------------
  // prescaler configuration
  // ---------------------------------------------------------------
  logic [7:0] prescale_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_q <= cirq_pkg::RST_PRESCALE;
    end else if (wr_prescale) begin
      prescale_q <= bus_i.wdata;
    end
  end

  // derived configuration outputs, registered
  logic [8:0] t0_div_d;
  logic [7:0] wd_div_d;
  always_comb begin
    t0_div_d = 9'h000;
    wd_div_d = 8'h00;
    if (prescale_q[cirq_pkg::BIT_PS_ASSIGN]) begin
      t0_div_d = 9'h001;
      wd_div_d = 8'h01 << prescale_q[2:0];
    end else begin
      t0_div_d = 9'h002 << prescale_q[2:0];
      wd_div_d = 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_o        <= cirq_pkg::RST_PRESCALE;
      pullups_enabled_o <= 1'b0;
      timer0_div_o      <= cirq_pkg::RST_T0_DIV;
      watchdog_div_o    <= cirq_pkg::RST_WD_DIV;
    end else begin
      prescale_o        <= prescale_q;
      pullups_enabled_o <= ~prescale_q[cirq_pkg::BIT_PULLUP_DIS];
      timer0_div_o      <= t0_div_d;
      watchdog_div_o    <= wd_div_d;
    end
  end

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  logic       ext_q;
  logic       ext_armed_q;
  logic [5:0] latch_q;
  logic [5:0] pin_en_q;
  logic       ext_edge;
  logic       pc_mismatch;
  // armed flag: no false edge when the pin idles high out of reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_q       <= 1'b0;
      ext_armed_q <= 1'b0;
    end else begin
      ext_q       <= ext_irq_pin_i;
      ext_armed_q <= 1'b1;
    end
  end
  assign ext_edge = ext_armed_q && (prescale_q[cirq_pkg::BIT_EDGE_SEL]
                  ? (ext_irq_pin_i && !ext_q)
                  : (!ext_irq_pin_i && ext_q));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= 6'h00;
    end else if (port_read_i) begin
      latch_q <= port_pins_i;
    end
  end
  assign pc_mismatch = |((port_pins_i ^ latch_q) & pin_en_q);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_en_q <= cirq_pkg::RST_PINCHG;
    end else if (wr_pinchg) begin
      pin_en_q <= bus_i.wdata[5:0] & cirq_pkg::PIN_MASK;
    end
  end

  // ---------------------------------------------------------------
  // interrupt control register
  // ---------------------------------------------------------------
  logic [7:0] intctl_q;
  logic [2:0] core_set;
  assign core_set = {timer0_ovf_i, ext_edge, pc_mismatch};
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intctl_q <= cirq_pkg::RST_INTCTL;
    end else begin
      if (wr_intctl) begin
        intctl_q <= bus_i.wdata | {5'h00, core_set};
      end else begin
        intctl_q <= intctl_q | {5'h00, core_set};
      end
    end
  end

  // ---------------------------------------------------------------
  // peripheral enables and flags
  // ---------------------------------------------------------------
  logic [7:0] penables_q;
  logic [7:0] pflags_q;
  logic [7:0] pset;
  always_comb begin
    pset = 8'h00;
    pset[cirq_pkg::BIT_NVM]  = nvm_write_done_i;
    pset[cirq_pkg::BIT_CONV] = conversion_done_i;
    pset[cirq_pkg::BIT_CMP]  = comparator_change_i;
    pset[cirq_pkg::BIT_TMR1] = timer1_ovf_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      penables_q <= cirq_pkg::RST_PERIPH;
    end else if (wr_penables) begin
      penables_q <= bus_i.wdata & cirq_pkg::PERIPH_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pflags_q <= cirq_pkg::RST_PERIPH;
    end else if (wr_pflags) begin
      pflags_q <= (bus_i.wdata | pset) & cirq_pkg::PERIPH_MASK;
    end else begin
      pflags_q <= pflags_q | pset;
    end
  end

  // ---------------------------------------------------------------
  // reset cause and trim
  // ---------------------------------------------------------------
  logic [1:0] rstcause_q;
  logic [5:0] trim_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rstcause_q <= cirq_pkg::RST_RSTCAUSE;
    end else begin
      if (wr_rstcause) begin
        rstcause_q <= bus_i.wdata[1:0];
      end
      if (por_event_i) begin
        rstcause_q[cirq_pkg::BIT_POR] <= 1'b0;
      end
      if (bod_event_i) begin
        rstcause_q[cirq_pkg::BIT_BOD] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_q <= cirq_pkg::RST_TRIM;
    end else if (wr_trim) begin
      trim_q <= bus_i.wdata[7:2];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_trim_field_o <= cirq_pkg::RST_TRIM;
    end else begin
      osc_trim_field_o <= trim_q;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  logic core_req;
  logic periph_req;
  assign core_req   = |(intctl_q[5:3] & intctl_q[2:0]);
  assign periph_req = intctl_q[cirq_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
                    && |(penables_q & pflags_q);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= intctl_q[cirq_pkg::BIT_GIE]
            && (core_req || periph_req);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    case (bus_i.addr)
      cirq_pkg::ADDR_INTCTL_B0: rdata_d = intctl_q;
      cirq_pkg::ADDR_INTCTL_B1: rdata_d = intctl_q;
      cirq_pkg::ADDR_PFLAGS:    rdata_d = pflags_q;
      cirq_pkg::ADDR_PRESCALE:  rdata_d = prescale_q;
      cirq_pkg::ADDR_PENABLES:  rdata_d = penables_q;
      cirq_pkg::ADDR_RSTCAUSE:  rdata_d = {6'h00, rstcause_q};
      cirq_pkg::ADDR_OSCTRIM:   rdata_d = {trim_q, 2'h0};
      cirq_pkg::ADDR_PINCHG:    rdata_d = {2'h0, pin_en_q};
      default:                  rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks: flags
  // ---------------------------------------------------------------
  a_flag_set_wins: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    timer0_ovf_i |=> intctl_q[cirq_pkg::BIT_T0_FLAG])
    else $error("timer0 flag lost");
  a_ext_edge_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ext_edge |=> intctl_q[cirq_pkg::BIT_EXT_FLAG])
    else $error("ext flag not set");
  a_t0_flag_sticky: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (intctl_q[cirq_pkg::BIT_T0_FLAG] && !wr_intctl)
      |=> intctl_q[cirq_pkg::BIT_T0_FLAG])
    else $error("timer0 flag dropped");
  a_ext_flag_sticky: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (intctl_q[cirq_pkg::BIT_EXT_FLAG] && !wr_intctl)
      |=> intctl_q[cirq_pkg::BIT_EXT_FLAG])
    else $error("ext flag dropped");
  a_pflag_sticky: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (pflags_q[cirq_pkg::BIT_TMR1] && !wr_pflags)
      |=> pflags_q[cirq_pkg::BIT_TMR1])
    else $error("peripheral flag dropped");
  a_periph_unused: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ((penables_q | pflags_q) & ~cirq_pkg::PERIPH_MASK) == 8'h00)
    else $error("unused peripheral bit set");

  // ---------------------------------------------------------------
  // checks: port change
  // ---------------------------------------------------------------
  sequence s_pc_mismatch;
    pc_mismatch;
  endsequence
  sequence s_pc_clear_try;
    wr_intctl && !bus_i.wdata[cirq_pkg::BIT_PC_FLAG];
  endsequence
  a_pc_mismatch_flag: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_pc_mismatch |=> intctl_q[cirq_pkg::BIT_PC_FLAG])
    else $error("port change flag not set");
  a_mismatch_resets: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (s_pc_mismatch and s_pc_clear_try) |=> intctl_q[cirq_pkg::BIT_PC_FLAG])
    else $error("mismatch flag cleared early");
  a_port_read_latch: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    port_read_i |=> latch_q == $past(port_pins_i))
    else $error("port read did not latch pins");

  // ---------------------------------------------------------------
  // checks: request gating
  // ---------------------------------------------------------------
  sequence s_periph_pending;
    intctl_q[cirq_pkg::BIT_GIE] && intctl_q[cirq_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
      && |(penables_q & pflags_q);
  endsequence
  a_gie_blocks_irq: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !intctl_q[cirq_pkg::BIT_GIE] |=> !irq_o)
    else $error("irq without global enable");
  a_peripheral_irq_enable_gates: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (!intctl_q[cirq_pkg::BIT_PERIPHERAL_IRQ_ENABLE] && !core_req) |=> !irq_o)
    else $error("peripheral irq without enable");
  a_irq_request: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (intctl_q[cirq_pkg::BIT_GIE] && intctl_q[cirq_pkg::BIT_T0_EN]
      && intctl_q[cirq_pkg::BIT_T0_FLAG]) |=> irq_o)
    else $error("irq not raised");
  a_periph_irq: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_periph_pending |=> irq_o)
    else $error("peripheral irq not raised");

  // ---------------------------------------------------------------
  // checks: configuration and reset cause
  // ---------------------------------------------------------------
  a_mirror_read: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus_i.rd && bus_i.addr == cirq_pkg::ADDR_INTCTL_B1)
      |=> rdata_o == $past(intctl_q))
    else $error("bank mirror read mismatch");
  a_pullup_follow: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_prescale ##2 1'b1 |-> pullups_enabled_o
      == !$past(bus_i.wdata[cirq_pkg::BIT_PULLUP_DIS], 2))
    else $error("pull-up disable not applied");
  a_cfg_export: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> prescale_o.timer0_clock_source
      == $past(prescale_q[cirq_pkg::BIT_T0_SRC])
      && prescale_o.timer0_source_edge
      == $past(prescale_q[cirq_pkg::BIT_T0_EDGE]))
    else $error("timer0 source config not exported");
  a_t0_div_rate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !prescale_q[cirq_pkg::BIT_PS_ASSIGN]
      |=> timer0_div_o == (9'h002 << $past(prescale_q[2:0])))
    else $error("timer0 division wrong");
  a_wd_div_rate: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    prescale_q[cirq_pkg::BIT_PS_ASSIGN]
      |=> timer0_div_o == 9'h001
      && watchdog_div_o == (8'h01 << $past(prescale_q[2:0])))
    else $error("watchdog division wrong");
  a_trim_out: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> osc_trim_field_o == $past(trim_q))
    else $error("trim field not exported");
  a_por_clears: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    por_event_i |=> !rstcause_q[cirq_pkg::BIT_POR])
    else $error("power-on status not cleared");
  a_bod_clears: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    bod_event_i |=> !rstcause_q[cirq_pkg::BIT_BOD])
    else $error("brown-out status not cleared");

endmodule : cirq_regs

// File: cirq_src.sv
// partner model: peripheral event sources, reset causes and pin levels
// assumes one bench command per clock; events leave one cycle later
`timescale 1ns/1ps
module cirq_src (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // bench command, 0 idles
  input  wire logic [3:0] cmd_i,
  // events and levels toward the block
  output logic            por_o,
  output logic            bod_o,
  output logic [4:0]      pulse_o,
  output logic            ext_pin_o,
  output logic [5:0]      pins_o,
  output logic            port_read_o
);
  // ---------------------------------------------------------------
  // event generation
  // ---------------------------------------------------------------
  // cmd 1..5 pulse timer0, nvm, conv, cmp, timer1; 6 ext pin toggle;
  // 7 port read; 8..13 toggle port pin; 14 power-on; 15 brown-out
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_o       <= 1'b0;
      bod_o       <= 1'b0;
      pulse_o     <= 5'h00;
      ext_pin_o   <= 1'b0;
      pins_o      <= 6'h00;
      port_read_o <= 1'b0;
    end else begin
      por_o       <= cmd_i == 4'hE;
      bod_o       <= cmd_i == 4'hF;
      pulse_o     <= 5'((6'h01 << cmd_i) >> 1);
      port_read_o <= cmd_i == 4'h7;
      if (cmd_i == 4'h6) begin
        ext_pin_o <= !ext_pin_o;
      end
      if (cmd_i[3] && cmd_i < 4'hE) begin
        pins_o[cmd_i[2:0]] <= !pins_o[cmd_i[2:0]];
      end
    end
  end
endmodule : cirq_src

// File: cirq_regs_test.sv
// testbench for the interrupt and configuration register block
// assumes cirq_src as event source; software role played by tasks
`timescale 1ns/1ps
module cirq_regs_test;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_n_i   = 1'b0;
  cirq_pkg::cirq_bus_t      bus_i     = '0;
  logic [3:0]               cmd       = 4'h0;
  logic [7:0]               rdata_o;
  logic [8:0]               timer0_div_o;
  logic [7:0]               watchdog_div_o;
  logic                     irq_o;
  logic                     pullups_enabled_o;
  logic                     por;
  logic                     brownout_status;
  logic                     ext_pin;
  logic                     port_read;
  logic [4:0]               pulse;
  logic [5:0]               pins;
  logic [5:0]               osc_trim_field_o;
  cirq_pkg::cirq_prescale_t prescale_o;
  int                       mismatches = 0;
  int                       num_checks = 0;
  localparam logic [7:0] RA [9] = '{8'h0B, 8'h8B, 8'h0C, 8'h81, 8'h8C,
                                    8'h8E, 8'h90, 8'h96, 8'h05};
  localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00,
                                    8'h03, 8'h80, 8'h00, 8'h00};
  localparam logic [3:0] SC [7] = '{4'h1, 4'h6, 4'h8, 4'h2, 4'h3, 4'h4,
                                    4'h5};
  localparam logic [7:0] SF [7] = '{8'h04, 8'h02, 8'h01, 8'h80, 8'h40,
                                    8'h08, 8'h01};
  localparam logic [7:0] SE [7] = '{8'h20, 8'h10, 8'h08, 8'h80, 8'h40,
                                    8'h08, 8'h01};

  always #2 clk_sys_i = !clk_sys_i;

  cirq_regs i_cirq_regs (
    .clk_sys_i           (clk_sys_i),
    .rst_n_i             (rst_n_i),
    .por_event_i         (por),
    .bod_event_i         (brownout_status),
    .bus_i               (bus_i),
    .rdata_o             (rdata_o),
    .timer0_ovf_i        (pulse[0]),
    .ext_irq_pin_i       (ext_pin),
    .port_pins_i         (pins),
    .port_read_i         (port_read),
    .nvm_write_done_i    (pulse[1]),
    .conversion_done_i   (pulse[2]),
    .comparator_change_i (pulse[3]),
    .timer1_ovf_i        (pulse[4]),
    .irq_o               (irq_o),
    .prescale_o          (prescale_o),
    .pullups_enabled_o   (pullups_enabled_o),
    .timer0_div_o        (timer0_div_o),
    .watchdog_div_o      (watchdog_div_o),
    .osc_trim_field_o    (osc_trim_field_o)
  );

  cirq_src i_cirq_src (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cmd_i       (cmd),
    .por_o       (por),
    .bod_o       (brownout_status),
    .pulse_o     (pulse),
    .ext_pin_o   (ext_pin),
    .pins_o      (pins),
    .port_read_o (port_read)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus_i.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus_i.rd <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask : rd

  task automatic fire(input logic [3:0] c);
    @(posedge clk_sys_i);
    cmd <= c;
    @(posedge clk_sys_i);
    cmd <= 4'h0;
    repeat (2) @(posedge clk_sys_i);
  endtask : fire

  task automatic idle;
    @(posedge clk_sys_i);
    #1;
  endtask : idle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rd(RA[i], RV[i]);
    chk("pullup", 8'(pullups_enabled_o), 8'h00);
    chk("tdiv", timer0_div_o, 8'h01);
    chk("wdiv", watchdog_div_o, 8'h80);
    chk("trim", 8'(osc_trim_field_o), 8'h20);
  endtask : t_reset

  task automatic t_prescale;
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[0], !i[0], i[0], !i[0], i[3], i[2:0]};
      wr(8'h81, v);
      rd(8'h81, v);
      chk("pullup", 8'(pullups_enabled_o), 8'(!v[7]));
      chk("cfg", 8'(prescale_o), v);
      chk("wdiv", watchdog_div_o, v[3] ? 8'h01 << v[2:0] : 8'h01);
      chk("tdiv", timer0_div_o, v[3] ? 9'h001 : 9'h002 << v[2:0]);
    end
    wr(8'h81, 8'hFF);
  endtask : t_prescale

  task automatic t_sources;
    logic       core;
    logic [7:0] fa;
    wr(8'h96, 8'h3F);
    fire(4'h7);
    for (int i = 0; i < 7; i++) begin
      core = i < 3;
      fa = core ? 8'h0B : 8'h0C;
      fire(SC[i]);
      rd(fa, SF[i]);
      chk("irq", 8'(irq_o), 8'h00);
      if (!core)
        wr(8'h8C, SE[i]);
      wr(8'h8B, core ? SE[i] | SF[i] : 8'h80);
      idle();
      chk("irq", 8'(irq_o), 8'h00);
      wr(8'h0B, core ? 8'h80 | SE[i] | SF[i] : 8'hC0);
      idle();
      chk("irq", 8'(irq_o), 8'h01);
      fire(4'h7);
      wr(fa, core ? 8'h80 | SE[i] : 8'h00);
      idle();
      chk("irq", 8'(irq_o), 8'h00);
      wr(8'h0B, 8'h00);
      wr(8'h8C, 8'h00);
    end
  endtask : t_sources

  task automatic t_port;
    wr(8'h96, 8'h01);
    fire(4'h7);
    fire(4'hB);
    rd(8'h0B, 8'h00);
    fire(4'h8);
    rd(8'h0B, 8'h01);
    wr(8'h0B, 8'h00);
    rd(8'h0B, 8'h01);
    fire(4'h7);
    wr(8'h0B, 8'h00);
    rd(8'h0B, 8'h00);
    wr(8'h96, 8'h00);
  endtask : t_port

  task automatic t_ext;
    wr(8'h81, 8'hBF);
    fire(4'h6);
    rd(8'h0B, 8'h02);
    wr(8'h0B, 8'h00);
    fire(4'h6);
    rd(8'h0B, 8'h00);
    wr(8'h81, 8'hFF);
  endtask : t_ext

  task automatic t_misc;
    fire(4'hE);
    rd(8'h8E, 8'h01);
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h03);
    fire(4'hF);
    rd(8'h8E, 8'h02);
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'hFC);
    chk("trim", 8'(osc_trim_field_o), 8'h3F);
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'hC9);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'hC9);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h8C, 8'h00);
    wr(8'h0C, 8'h00);
    // clear lands in the same cycle as the event
    fork
      fire(4'h2);
      begin
        @(posedge clk_sys_i);
        wr(8'h0C, 8'h00);
      end
    join
    rd(8'h0C, 8'h80);
  endtask : t_misc

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_prescale();
    t_sources();
    t_port();
    t_ext();
    t_misc();
    test_done();
  end

  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule : cirq_regs_test
